// ---- design/acsc_pkg.sv ----
// constants and types shared by the converter control block
package acsc_pkg;
    localparam int CLK_MHZ = 25;
    localparam int CONV60_NS = 133000000;
    localparam int CONV50_NS = 160000000;
    localparam int CONV60_CYC = CONV60_NS / 1000 * CLK_MHZ;
    localparam int CONV50_CYC = CONV50_NS / 1000 * CLK_MHZ;
    localparam int EXT_CONV_TICKS = 20510;
    localparam int NOTCH_DIV = 2560;
    localparam int FRAME_BITS = 32;
    localparam int SCK_DIV = 8;
    localparam int DOUT_INT_NS = 1670000;
    localparam int CONV_TICK_CYC =
        DOUT_INT_NS * CLK_MHZ / 1000 / (FRAME_BITS * SCK_DIV);
    localparam int SCK_HALF_CYC = CONV_TICK_CYC * SCK_DIV / 2;
    localparam int EXT_MIN_HZ = 2560;
    localparam int EXT_LOSS_NS = 1000000000 / EXT_MIN_HZ;
    localparam int EXT_LOSS_CYC = EXT_LOSS_NS * CLK_MHZ / 1000;
    localparam int SAMPLE_W = 30;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 22;
    localparam int IDLE_W = 14;
    localparam int TICK_W = 8;
    localparam int BIT_W = 5;
    localparam logic [BIT_W-1:0] LAST_BIT = 5'h1f;
    localparam logic EOC_DONE = 1'b0;
    typedef enum logic [1:0] {ST_CONV, ST_SLEEP, ST_DOUT} acsc_state_e;
endpackage

// ---- design/acsc_fifo.sv ----
// result fifo between the decimation filter and the output shift register
`timescale 1ns/10ps
module acsc_fifo #(
    parameter int W = 30,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } acsc_fifo_s;
    acsc_fifo_s s_r, s_nxt;
    logic push, pop;

    assign in_ready = s_r.cnt != FULL;
    assign out_valid = s_r.cnt != '0;
    assign out_data = s_r.mem[s_r.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointers wrap on a power-of-two depth
    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        if (push && !pop) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end else if (pop && !push) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// ---- design/acsc_top.sv ----
// conversion clock select, state sequencing and 3-wire serial port
`timescale 1ns/10ps
module acsc_top #(
    parameter int CONV60_CYC = acsc_pkg::CONV60_CYC,
    parameter int CONV50_CYC = acsc_pkg::CONV50_CYC,
    parameter int EXT_LOSS_CYC = acsc_pkg::EXT_LOSS_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic rejection_clock_select,
    input wire logic cs_n,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic samp_valid,
    input wire logic [acsc_pkg::SAMPLE_W-1:0] samp_data,
    output logic samp_ready,
    output logic notch_50hz,
    output logic ext_clk_on,
    output logic osc_en,
    output logic conv_chan,
    output logic converting
);
    import acsc_pkg::*;

    localparam logic [CNT_W-1:0] LIM60 = CNT_W'(CONV60_CYC);
    localparam logic [CNT_W-1:0] LIM50 = CNT_W'(CONV50_CYC);
    localparam logic [CNT_W-1:0] EXT_LIM = CNT_W'(EXT_CONV_TICKS);
    localparam logic [IDLE_W-1:0] LOSS = IDLE_W'(EXT_LOSS_CYC);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CONV_TICK_CYC - 1);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(SCK_HALF_CYC - 1);

    typedef struct packed {
        acsc_state_e state;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] lim;
        logic ch;
        logic [FRAME_BITS-1:0] sreg;
        logic [BIT_W-1:0] bits;
        logic started;
        logic int_sck;
        logic pend;
        logic sck;
        logic [TICK_W-1:0] tick;
        logic [1:0] ph;
        logic rej_q;
        logic armed;
        logic ext;
        logic [IDLE_W-1:0] idle;
        logic cs_q;
        logic sck_q;
        logic sdo;
    } acsc_top_s;

    acsc_top_s s_r, s_nxt;
    logic rej_rise, conv_tick, sck_rise, sck_fall, conv_done;
    logic fifo_vld;
    logic [SAMPLE_W-1:0] fifo_word;

    // rising edge of a level against its value one clock earlier
    function automatic logic edge_up(input logic now, input logic was);
        return now & ~was;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // result buffer: filter words wait here until a conversion ends

    acsc_fifo #(
        .W(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(samp_valid),
        .in_data(samp_data),
        .in_ready(samp_ready),
        .out_valid(fifo_vld),
        .out_data(fifo_word),
        .out_ready(conv_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // events of this clock

    assign rej_rise = edge_up(rejection_clock_select, s_r.rej_q);
    // external ticks replace the oscillator divider
    assign conv_tick = s_r.ext ? rej_rise : (s_r.tick == TICK_LAST);
    // own clock edges in internal mode, pin edges in external mode
    assign sck_rise = s_r.int_sck ?
        (conv_tick && s_r.ph == 2'h3 && !s_r.sck) :
        edge_up(sck_in, s_r.sck_q);
    assign sck_fall = s_r.int_sck ?
        (conv_tick && s_r.ph == 2'h3 && s_r.sck) :
        edge_up(s_r.sck_q, sck_in);
    // external mode counts clock periods, internal mode counts cycles
    assign conv_done = (s_r.state == ST_CONV) &&
        (s_r.ext ? (s_r.cnt >= EXT_LIM) :
                   (s_r.cnt >= s_r.lim - 1'b1));

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_nxt = s_r;
        s_nxt.rej_q = rejection_clock_select;
        s_nxt.cs_q = cs_n;
        s_nxt.sck_q = sck_in;

        // oscillator divider runs free; it does not care about the state
        if (s_r.tick == TICK_LAST) begin
            s_nxt.tick = '0;
        end else begin
            s_nxt.tick = s_r.tick + 1'b1;
        end

        // two rising edges within one slow period make an external clock;
        // a single level change for a notch choice never qualifies
        if (rej_rise) begin
            s_nxt.idle = '0;
            s_nxt.armed = 1'b1;
            if (s_r.armed) begin
                s_nxt.ext = 1'b1;
            end
        end else if (s_r.idle == LOSS) begin
            s_nxt.armed = 1'b0;
            s_nxt.ext = 1'b0;
        end else begin
            s_nxt.idle = s_r.idle + 1'b1;
        end

        // serial clock mode: after reset, then on each select fall
        if (s_r.pend || (!cs_n && s_r.cs_q)) begin
            s_nxt.int_sck = sck_in;
            s_nxt.pend = 1'b0;
        end

        unique case (s_r.state)
            ST_CONV: begin
                // a source switch mid-way just mixes units for this result
                if (s_r.ext) begin
                    s_nxt.cnt = s_r.cnt + CNT_W'(rej_rise);
                end else begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                end
                if (conv_done) begin
                    // keep old result bits if the filter had none ready
                    s_nxt.sreg = {EOC_DONE, s_r.ch,
                        fifo_vld ? fifo_word : s_r.sreg[SAMPLE_W-1:0]};
                    s_nxt.ch = ~s_r.ch;
                    if (cs_n) begin
                        s_nxt.state = ST_SLEEP;
                    end else begin
                        s_nxt.state = ST_DOUT;
                    end
                end
            end
            ST_SLEEP: begin
                if (!cs_n) begin
                    s_nxt.state = ST_DOUT;
                end
            end
            ST_DOUT: begin
                if (cs_n) begin
                    // before the first clock only a status check was made
                    s_nxt.state = s_r.started ? ST_CONV : ST_SLEEP;
                end else begin
                    if (s_r.int_sck && conv_tick) begin
                        s_nxt.ph = s_r.ph + 1'b1;
                        if (s_r.ph == 2'h3) begin
                            s_nxt.sck = ~s_r.sck;
                        end
                    end
                    if (sck_rise) begin
                        s_nxt.started = 1'b1;
                    end
                    if (sck_fall) begin
                        if (s_r.bits == LAST_BIT) begin
                            s_nxt.state = ST_CONV;
                        end else begin
                            s_nxt.sreg = {s_r.sreg[FRAME_BITS-2:0], 1'b0};
                            s_nxt.bits = s_r.bits + 1'b1;
                        end
                    end
                end
            end
        endcase

        // fresh output frame or fresh conversion
        if (s_nxt.state == ST_DOUT && s_r.state != ST_DOUT) begin
            s_nxt.bits = '0;
            s_nxt.started = 1'b0;
            s_nxt.sck = 1'b0;
            s_nxt.ph = '0;
        end
        if (s_nxt.state == ST_CONV && s_r.state != ST_CONV) begin
            s_nxt.cnt = '0;
            // pin is read for lim only here and at reset, so later changes hit no result
            s_nxt.lim = rejection_clock_select ? LIM50 : LIM60;
            s_nxt.sck = 1'b0;
        end

        // flag in convert and sleep, frame bit during output
        if (s_nxt.state == ST_DOUT) begin
            s_nxt.sdo = s_nxt.sreg[FRAME_BITS-1];
        end else begin
            s_nxt.sdo = s_nxt.state == ST_CONV;
        end
    end

    // power-up starts a conversion and defers the mode sample one clock
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.state <= ST_CONV;
            s_r.lim <= rejection_clock_select ? LIM50 : LIM60;
            s_r.rej_q <= rejection_clock_select; // no false edge after reset
            s_r.pend <= 1'b1;
            s_r.int_sck <= 1'b1;
            s_r.sdo <= 1'b1;
            s_r.cs_q <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins and status

    assign sdo_out = s_r.sdo;
    assign sdo_oe = ~cs_n;
    assign sck_out = s_r.sck;
    assign sck_oe = s_r.int_sck & ~cs_n;
    assign notch_50hz = s_r.lim == LIM50;
    assign ext_clk_on = s_r.ext;
    assign osc_en = ~s_r.ext;
    assign conv_chan = s_r.ch;
    assign converting = s_r.state == ST_CONV;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // helper: cycles since the last own clock toggle within one frame
    logic [CNT_W-1:0] gap_r;
    logic tog_seen_r, int_run_r;
    logic [CNT_W-1:0] age_r;
    always_ff @(posedge sys_clk) begin
        if (rst || s_r.state != ST_DOUT || s_r.ext != s_nxt.ext) begin
            gap_r <= '0;
            tog_seen_r <= 1'b0;
        end else if (s_nxt.sck != s_r.sck) begin
            gap_r <= '0;
            tog_seen_r <= 1'b1;
        end else begin
            gap_r <= gap_r + 1'b1;
        end
    end

    // helper: age of a conversion run wholly on the oscillator
    always_ff @(posedge sys_clk) begin
        if (rst || s_r.state != ST_CONV) begin
            age_r <= '0;
            int_run_r <= ~s_r.ext;
        end else begin
            age_r <= age_r + 1'b1;
            if (s_r.ext) begin
                int_run_r <= 1'b0;
            end
        end
    end

    sequence conv_start_s;
        (s_r.state != ST_CONV) ##1 (s_r.state == ST_CONV);
    endsequence

    sequence last_fall_s;
        (s_r.state == ST_DOUT) && !cs_n && sck_fall && s_r.bits == LAST_BIT;
    endsequence

    sequence mid_fall_s;
        (s_r.state == ST_DOUT) && !cs_n && sck_fall && s_r.bits != LAST_BIT;
    endsequence

    notch_pick_a: assert property (conv_start_s |->
        s_r.lim == ($past(rejection_clock_select) ? LIM50 : LIM60))
        else $error("conversion length does not follow the select pin");

    conv_len_a: assert property (
        (s_r.state == ST_CONV && conv_done && int_run_r) |->
        age_r == s_r.lim - 1'b1)
        else $error("internal conversion length is wrong");

    ext_loss_a: assert property (
        (s_r.ext && !rej_rise && s_r.idle == LOSS) |=> !s_r.ext && osc_en)
        else $error("oscillator not restored after external clock loss");

    ext_detect_a: assert property (
        (rej_rise && s_r.armed) |=> s_r.ext && !osc_en)
        else $error("external clock not detected");

    sdo_hiz_a: assert property (cs_n |-> !sdo_oe)
        else $error("data out driven with chip select high");

    eoc_flag_a: assert property (
        (!cs_n && s_r.state != ST_DOUT) |-> sdo_out == converting)
        else $error("end-of-conversion flag wrong on data out");

    shift_bit_a: assert property (mid_fall_s |=>
        sdo_out == $past(s_r.sreg[FRAME_BITS-2]))
        else $error("next frame bit not shown after falling edge");

    frame_end_a: assert property (last_fall_s |=>
        converting && sdo_out && s_r.cnt == '0)
        else $error("32nd falling edge did not restart conversion");

    abort_a: assert property (
        (s_r.state == ST_DOUT && s_r.started && cs_n) |=> converting)
        else $error("chip select rise did not abort the output");

    sleep_entry_a: assert property ((conv_done && cs_n) |=>
        s_r.state == ST_SLEEP ##1 s_r.state == ST_SLEEP || !cs_n)
        else $error("finished conversion did not go to sleep");

    sck_div_a: assert property (
        (s_r.state == ST_DOUT && s_r.int_sck && !s_r.ext && tog_seen_r &&
         s_nxt.state == ST_DOUT && s_nxt.sck != s_r.sck) |->
        gap_r == HALF_LAST)
        else $error("internal serial clock half period wrong");

    mode_pick_a: assert property (
        ($fell(cs_n)) |=> s_r.int_sck == $past(sck_in))
        else $error("serial clock mode not sampled at select fall");

    hold_result_a: assert property (
        (s_r.state == ST_SLEEP && cs_n) |=> $stable(s_r.sreg))
        else $error("held result changed during sleep");

    chan_bit_a: assert property (conv_done |=>
        s_r.sreg[FRAME_BITS-2] == $past(s_r.ch) && !s_r.sreg[FRAME_BITS-1])
        else $error("frame status bits wrong at latch");
endmodule

// ---- tb/acsc_host.sv ----
// host model on the far side of the 3-wire serial port
`timescale 1ns/10ps
module acsc_host (
    input wire logic sys_clk,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    output logic cs_n,
    output logic sck_in,
    output logic frame_valid,
    output logic [31:0] frame_word,
    output int half_cyc
);
    logic sck_en;
    logic sck_drv;
    logic sdo_last;
    logic sdo_pin;
    logic [31:0] shift;
    int run;
    ////////////////////////////////////////////////////////////
    // a released clock line floats high on its weak pull-up; a released
    // data line shows the inverse so a stale level never passes as data
    assign sck_in = sck_oe ? sck_out : (sck_en ? sck_drv : 1'b1);
    assign sdo_pin = sdo_oe ? sdo_out : ~sdo_last;

    // last driven data level, and length of the latest clock high phase
    always @(posedge sys_clk) begin
        if (sdo_oe) begin
            sdo_last <= sdo_out;
        end
        run <= sck_out ? run + 1 : 0;
        if (!sck_out && run != 0) begin
            half_cyc <= run;
        end
    end

    initial begin
        cs_n = 1'b1;
        sck_en = 1'b1;
        sck_drv = 1'b0;
        sdo_last = 1'b0;
        frame_valid = 1'b0;
        frame_word = '0;
        run = 0;
    end

    // clock held low selects the external clock, released the internal
    task automatic cs_fall(input logic ext);
        @(negedge sys_clk);
        sck_en = ext;
        sck_drv = 1'b0;
        repeat (2) @(negedge sys_clk);
        cs_n = 1'b0;
    endtask

    task automatic cs_rise();
        @(negedge sys_clk);
        cs_n = 1'b1;
    endtask

    // bounded wait for the end-of-conversion flag to drop
    task automatic wait_eoc();
        for (int i = 0; i < 2000 && sdo_pin !== 1'b0; i++) begin
            @(negedge sys_clk);
        end
    endtask

    task automatic publish();
        frame_word = shift;
        frame_valid = 1'b1;
        @(negedge sys_clk);
        frame_valid = 1'b0;
    endtask

    // host clock: bit taken before each rise, two cycles per phase
    task automatic ext_bits(input int n, input logic pub);
        for (int i = 0; i < n; i++) begin
            shift = {shift[30:0], sdo_pin};
            sck_drv = 1'b1;
            repeat (2) @(negedge sys_clk);
            sck_drv = 1'b0;
            repeat (2) @(negedge sys_clk);
        end
        if (pub) begin
            publish();
        end
    endtask

    // device clock: bit taken on each of its rising edges
    task automatic int_bits();
        for (int i = 0; i < 32; i++) begin
            @(posedge sck_out);
            shift = {shift[30:0], sdo_pin};
        end
        @(negedge sck_out);
        @(negedge sys_clk);
        publish();
    endtask
endmodule

// ---- tb/test_adc_conversion_clock_and_serial_control.sv ----
// self-checking bench for the converter control block
`timescale 1ns/10ps
module test_adc_conversion_clock_and_serial_control;
    import acsc_pkg::*;
    // short conversions keep the run small; the clock divider is fixed
    localparam int C60 = 200;
    localparam int C50 = 300;
    localparam int LOSS = 50;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic rejection_clock_select = 1'b0;
    logic samp_valid = 1'b0;
    logic [SAMPLE_W-1:0] samp_data = '0;
    logic cs_n, sck_in, sck_out, sck_oe, sdo_out, sdo_oe, samp_ready;
    logic notch_50hz, ext_clk_on, osc_en, conv_chan, converting;
    logic frame_valid;
    logic [31:0] frame_word;
    logic [31:0] rnd;
    int half_cyc;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 32'h187f;
    int ck = 0;
    int conv_run = 0;
    int last_run = 0;
    logic [SAMPLE_W-1:0] words[$];
    logic [31:0] expq[$];

    always #20 sys_clk = ~sys_clk;

    acsc_top #(.CONV60_CYC(C60), .CONV50_CYC(C50), .EXT_LOSS_CYC(LOSS)) dut (
        .sys_clk(sys_clk), .rst(rst),
        .rejection_clock_select(rejection_clock_select),
        .cs_n(cs_n), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .samp_valid(samp_valid),
        .samp_data(samp_data), .samp_ready(samp_ready),
        .notch_50hz(notch_50hz), .ext_clk_on(ext_clk_on), .osc_en(osc_en),
        .conv_chan(conv_chan), .converting(converting));

    acsc_host host (
        .sys_clk(sys_clk), .sck_out(sck_out), .sck_oe(sck_oe),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .cs_n(cs_n), .sck_in(sck_in),
        .frame_valid(frame_valid), .frame_word(frame_word),
        .half_cyc(half_cyc));
    ////////////////////////////////////////////////////////////
    task automatic check_frame(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] frame expected %h seen %h", exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp,
                             input logic got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // frame of the next conversion: flag low, channel, buffered word
    task automatic expect_frame();
        expq.push_back({1'b0, ck[0], words.pop_front()});
        ck++;
    endtask

    // each captured frame is compared with the oldest note
    always @(posedge sys_clk) begin
        if (frame_valid) begin
            check_frame(expq.size() != 0 ? expq.pop_front() : 32'hx,
                        frame_word);
        end
    end

    // convert-state length, and the ceiling that cuts a hang short
    always @(posedge sys_clk) begin
        conv_run <= converting ? conv_run + 1 : 0;
        if (!converting && conv_run != 0) begin
            last_run <= conv_run;
        end
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        check_bit("sdo_oe idle", 1'b0, sdo_oe);
        @(negedge sys_clk);
        // fill the buffer while nobody reads; the seventeenth is refused
        for (int i = 0; i < 17; i++) begin
            rnd = $random(seed);
            samp_data = rnd[SAMPLE_W-1:0];
            samp_valid = 1'b1;
            if (i < 16) begin
                words.push_back(samp_data);
            end else begin
                check_bit("buffer full", 1'b0, samp_ready);
            end
            @(negedge sys_clk);
        end
        samp_valid = 1'b0;
        // chip select held low: back-to-back reads on the host clock
        host.cs_fall(1'b1);
        for (int f = 0; f < 13; f++) begin
            expect_frame();
            host.wait_eoc();
            check_bit("host clock mode", 1'b0, sck_oe);
            host.ext_bits(32, 1'b1);
            check_bit("eoc after frame", 1'b1, sdo_out);
            check_bit("restart", 1'b1, converting);
            check_bit("channel", ck[0], conv_chan);
            if (f == 2) begin
                check_bit("notch 60", 1'b0, notch_50hz);
                check_bit("conv60", 1'b1, last_run inside {C60, C60 + 1});
            end
        end
        // abort after five clocks; that word is lost
        void'(words.pop_front());
        ck++;
        host.wait_eoc();
        host.ext_bits(5, 1'b0);
        host.cs_rise();
        repeat (2) @(negedge sys_clk);
        check_bit("abort restart", 1'b1, converting);
        check_bit("sdo released", 1'b0, sdo_oe);
        repeat (C60 + 10) @(negedge sys_clk);
        check_bit("sleep", 1'b0, converting);
        rejection_clock_select = 1'b1;
        expect_frame();
        host.cs_fall(1'b1);
        repeat (2) @(negedge sys_clk);
        check_bit("eoc in sleep", 1'b0, host.sdo_pin);
        host.ext_bits(32, 1'b1);
        // device clock read of a 50Hz conversion, flag high meanwhile
        host.cs_rise();
        expect_frame();
        host.cs_fall(1'b0);
        repeat (2) @(negedge sys_clk);
        check_bit("eoc converting", 1'b1, host.sdo_pin);
        check_bit("device clock", 1'b1, sck_oe);
        host.int_bits();
        repeat (2) @(negedge sys_clk);
        check_bit("eoc int frame", 1'b1, sdo_out);
        check_bit("sck idle", 1'b0, sck_out);
        check_bit("notch 50", 1'b1, notch_50hz);
        check_bit("conv50", 1'b1, last_run inside {C50, C50 + 1});
        check_bit("half period", 1'b1, half_cyc == SCK_HALF_CYC);
        check_bit("buffer drained", 1'b1, samp_ready);
        host.cs_rise();
        // external conversion clock on the select pin, then its loss
        for (int i = 0; i < 20; i++) begin
            repeat (10) @(negedge sys_clk);
            rejection_clock_select = ~rejection_clock_select;
        end
        check_bit("ext clock seen", 1'b1, ext_clk_on);
        check_bit("osc off", 1'b0, osc_en);
        repeat (LOSS + 5) @(negedge sys_clk);
        check_bit("ext clock lost", 1'b0, ext_clk_on);
        check_bit("osc back", 1'b1, osc_en);
        give_verdict();
    end
endmodule
